// [design/triggered_pipeline_capture.v]
// The implementer's own choices: the register offsets and the APB slave port.
`timescale 1ns/1ps
`include "capture_defines.vh"
module triggered_pipeline_capture #(
	parameter PIPE_AW = 8,
	parameter MEB_AW = 8,
	parameter EV_AW = 8
) (
	// Clock, reset, enable.
	input wire pclk,
	input wire presetn,
	input wire ce,
	// APB slave.
	input wire psel,
	input wire penable,
	input wire pwrite,
	input wire [7:0] paddr,
	input wire [31:0] pwdata,
	output reg [31:0] prdata,
	output wire pready,
	output wire pslverr,
	// Front panel inputs, asynchronous.
	input wire [31:0] data_in,
	input wire acq_clk_in,
	input wire trig_in,
	input wire or_in,
	// Open-collector busy, low on the wire means busy.
	input wire busy_n_i,
	output wire busy_n_o,
	output wire busy_n_oe,
	// Front panel outputs.
	output reg or_out,
	output reg [15:0] group_or_output,
	output reg [7:0] v1_level,
	output reg [7:0] v2_level,
	// Interrupter.
	input wire irq_ack,
	output wire irq_req,
	output wire [2:0] irq_level,
	output wire [7:0] irq_vector
);
	localparam PIPE_N = 1 << PIPE_AW;
	localparam MEB_N = 1 << MEB_AW;
	localparam EV_N = 1 << EV_AW;

	reg [31:0] pipe_mem [0:PIPE_N-1];
	reg [31:0] meb_mem [0:MEB_N-1];
	reg [7:0] ev_mem [0:EV_N-1];

	// Synchronisers for every front panel input.
	reg [31:0] din_s1_ff, din_s2_ff;
	reg [2:0] clk_s_ff;
	reg [1:0] trig_s_ff, busy_s_ff, orin_s_ff;
	reg trig_d_ff;

	// Control and configuration.
	reg [8:0] intr_ff;
	reg [7:0] cfg_ff;
	reg acq_en_ff;
	reg load_ff;
	reg [7:0] wr_byte_ff;
	reg [7:0] len_ff;
	reg [1:0] preset_step_ff;
	reg trig_irq_ff;

	// Circular buffer state.
	reg [PIPE_AW-1:0] pwp_ff;
	reg [31:0] dly1_ff, dly2_ff;

	// Transfer state.
	reg [3:0] blk_cnt_ff;
	reg sw_trig_ff;

	// Multi-event buffer and event FIFO.
	reg [MEB_AW-1:0] mwp_ff, mrp_ff;
	reg [MEB_AW:0] mcnt_ff;
	reg [EV_AW-1:0] ewp_ff, erp_ff;
	reg [EV_AW:0] ecnt_ff;
	reg [7:0] evnum_ff;

	wire [4:0] idx = paddr[6:2];
	wire addr_ok = (paddr[7] == 1'b0) && (paddr[1:0] == 2'b00) && (idx[0] == 1'b0)
		&& (idx <= `IDX_TRIGGER);
	wire setup = psel && !penable;
	wire acc = psel && penable;
	wire wr = acc && pwrite && addr_ok;
	wire rd = acc && !pwrite && addr_ok;
	wire soft_reset = wr && (idx == `IDX_RESET);
	wire soft_clock = wr && (idx == `IDX_CLOCK);
	wire soft_trig = wr && (idx == `IDX_TRIGGER);

	assign pready = 1'b1;
	assign pslverr = acc && !addr_ok;

	wire meb_full = (mcnt_ff == MEB_N[MEB_AW:0]);
	wire meb_empty = (mcnt_ff == {(MEB_AW+1){1'b0}});
	wire ev_full = (ecnt_ff == EV_N[EV_AW:0]);
	wire ev_empty = (ecnt_ff == {(EV_AW+1){1'b0}});
	wire almost_full_n = (mcnt_ff < (MEB_N[MEB_AW:0] - `ALMOST_FULL_MARGIN));
	wire module_busy = !almost_full_n;
	wire ext_busy = !busy_s_ff[1];
	// External signals pass only when enabled and the buffer has room.
	wire ext_en = acq_en_ff && almost_full_n;
	wire halt = meb_full || ext_busy;
	wire clk_edge = clk_s_ff[1] && !clk_s_ff[2];
	wire ext_tick = ext_en && clk_edge;
	wire test_tick = soft_clock && load_ff;
	wire tick = (ext_tick || test_tick) && !halt;
	wire trig_lvl = ext_en && trig_s_ff[1];
	wire trig_rise = trig_lvl && !trig_d_ff;
	wire trigger = trig_rise || soft_trig;
	wire stream_mode = (cfg_ff[3:0] == 4'h0);
	wire [31:0] tick_word = test_tick ? {4{wr_byte_ff}} : din_s2_ff;
	wire [PIPE_AW-1:0] prp = pwp_ff - len_ff[PIPE_AW-1:0];
	// A zero length reads the word being stored; two stages add the fixed delay.
	wire [31:0] oldest = (len_ff == 8'h00) ? tick_word : pipe_mem[prp];
	wire xfer_on = stream_mode ? (trig_lvl || sw_trig_ff) : (blk_cnt_ff != 4'h0);
	wire meb_push = tick && xfer_on && !meb_full;
	wire meb_pop = rd && (idx == `IDX_FIFO_HI) && !meb_empty;
	wire ev_push = trigger && !ev_full;
	wire ev_pop = rd && (idx == `IDX_EVNUM) && !ev_empty;
	wire [3:0] status = {module_busy, almost_full_n, !meb_empty, !ev_empty};
	wire full_irq = !almost_full_n;

	assign irq_level = intr_ff[`INT_LVL_HI:`INT_LVL_LO];
	assign irq_vector = {intr_ff[`INT_ID_HI:0], 2'b00};
	assign irq_req = (irq_level != 3'b000) && (trig_irq_ff || full_irq);
	assign busy_n_o = 1'b0;
	assign busy_n_oe = cfg_ff[`CFG_BUSY_EN] && module_busy;

	// Input synchronisers and trigger edge memory.
	always @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			din_s1_ff <= 32'h0000_0000;
			din_s2_ff <= 32'h0000_0000;
			clk_s_ff <= 3'b000;
			trig_s_ff <= 2'b00;
			busy_s_ff <= 2'b11;
			orin_s_ff <= 2'b00;
			trig_d_ff <= 1'b0;
		end else if (ce) begin
			din_s1_ff <= data_in;
			din_s2_ff <= din_s1_ff;
			clk_s_ff <= {clk_s_ff[1], clk_s_ff[0], acq_clk_in};
			trig_s_ff <= {trig_s_ff[0], trig_in};
			busy_s_ff <= {busy_s_ff[0], busy_n_i};
			orin_s_ff <= {orin_s_ff[0], or_in};
			trig_d_ff <= trig_lvl;
		end
	end

	// Group OR patterns over the synchronised inputs.
	reg [15:0] nxt_group;
	integer g;
	always @* begin
		nxt_group = 16'h0000;
		for (g = 0; g < 16; g = g + 1) begin
			case (cfg_ff[6:4])
			3'b000: nxt_group[g] = |din_s2_ff[2*g +: 2];
			3'b001: nxt_group[g] = (g < 8) ? |din_s2_ff[(4*g)%32 +: 4] : 1'b0;
			3'b010: nxt_group[g] = (g < 4) ? |din_s2_ff[(8*g)%32 +: 8] : 1'b0;
			3'b011: nxt_group[g] = (g < 2) ? |din_s2_ff[(16*g)%32 +: 16] : 1'b0;
			default: nxt_group[g] = 1'b0;
			endcase
		end
	end

	always @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			group_or_output <= 16'h0000;
			or_out <= 1'b0;
		end else if (ce) begin
			group_or_output <= nxt_group;
			or_out <= (|din_s2_ff) || orin_s_ff[1];
		end
	end

	// Register writes, configuration and length preset.
	always @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			intr_ff <= 9'h000;
			cfg_ff <= 8'h00;
			acq_en_ff <= 1'b0;
			load_ff <= 1'b1;
			wr_byte_ff <= 8'h00;
			len_ff <= 8'h00;
			preset_step_ff <= 2'b00;
			v1_level <= 8'h00;
			v2_level <= 8'h00;
		end else if (ce) begin
			if (soft_reset) begin
				intr_ff <= 9'h000;
				preset_step_ff <= 2'b00;
			end else if (soft_clock && !load_ff) begin
				// The second clocked value while preset is low sets the length.
				if (preset_step_ff == 2'b01) begin
					len_ff <= `LEN_MAX - wr_byte_ff;
				end
				if (preset_step_ff != 2'b11) begin
					preset_step_ff <= preset_step_ff + 2'b01;
				end
			end
			if (wr) begin
				case (idx)
				`IDX_INTR: intr_ff <= pwdata[8:0];
				`IDX_CONFIG: cfg_ff <= pwdata[7:0];
				`IDX_ACQ: acq_en_ff <= !pwdata[`ACQ_DIS_BIT];
				`IDX_V1: v1_level <= pwdata[7:0];
				`IDX_V2: v2_level <= pwdata[7:0];
				`IDX_FIFO_WR: wr_byte_ff <= pwdata[7:0];
				`IDX_LOAD: load_ff <= pwdata[0];
				default: ;
				endcase
			end
		end
	end

	// Circular buffer: store on each tick, two stages add the fixed delay.
	always @(posedge pclk) begin
		if (ce && tick) begin
			pipe_mem[pwp_ff] <= tick_word;
		end
	end

	always @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			pwp_ff <= {PIPE_AW{1'b0}};
			dly1_ff <= 32'h0000_0000;
			dly2_ff <= 32'h0000_0000;
		end else if (ce) begin
			if (soft_reset) begin
				pwp_ff <= {PIPE_AW{1'b0}};
			end else if (tick) begin
				pwp_ff <= pwp_ff + 1'b1;
				dly1_ff <= oldest;
				dly2_ff <= dly1_ff;
			end
		end
	end

	// Transfer control and trigger interrupt.
	always @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			blk_cnt_ff <= 4'h0;
			sw_trig_ff <= 1'b0;
			trig_irq_ff <= 1'b0;
		end else if (ce) begin
			if (soft_reset) begin
				blk_cnt_ff <= 4'h0;
				sw_trig_ff <= 1'b0;
				trig_irq_ff <= 1'b0;
			end else begin
				if (trigger && !stream_mode) begin
					blk_cnt_ff <= cfg_ff[3:0];
				end else if (meb_push && !stream_mode) begin
					blk_cnt_ff <= blk_cnt_ff - 4'h1;
				end
				if (soft_trig) begin
					sw_trig_ff <= 1'b1;
				end else if (tick) begin
					sw_trig_ff <= 1'b0;
				end
				if (trigger) begin
					trig_irq_ff <= 1'b1;
				end else if (irq_ack) begin
					trig_irq_ff <= 1'b0;
				end
			end
		end
	end

	// Multi-event buffer and event FIFO storage.
	always @(posedge pclk) begin
		if (ce && meb_push) begin
			meb_mem[mwp_ff] <= dly2_ff;
		end
		if (ce && ev_push) begin
			ev_mem[ewp_ff] <= evnum_ff;
		end
	end

	always @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			mwp_ff <= {MEB_AW{1'b0}};
			mrp_ff <= {MEB_AW{1'b0}};
			mcnt_ff <= {(MEB_AW+1){1'b0}};
			ewp_ff <= {EV_AW{1'b0}};
			erp_ff <= {EV_AW{1'b0}};
			ecnt_ff <= {(EV_AW+1){1'b0}};
			evnum_ff <= 8'h00;
		end else if (ce) begin
			if (soft_reset) begin
				mwp_ff <= {MEB_AW{1'b0}};
				mrp_ff <= {MEB_AW{1'b0}};
				mcnt_ff <= {(MEB_AW+1){1'b0}};
				ewp_ff <= {EV_AW{1'b0}};
				erp_ff <= {EV_AW{1'b0}};
				ecnt_ff <= {(EV_AW+1){1'b0}};
				evnum_ff <= 8'h00;
			end else begin
				if (meb_push) begin
					mwp_ff <= mwp_ff + 1'b1;
				end
				if (meb_pop) begin
					mrp_ff <= mrp_ff + 1'b1;
				end
				if (meb_push && !meb_pop) begin
					mcnt_ff <= mcnt_ff + 1'b1;
				end else if (meb_pop && !meb_push) begin
					mcnt_ff <= mcnt_ff - 1'b1;
				end
				if (trigger) begin
					evnum_ff <= evnum_ff + 8'h01;
				end
				if (ev_push) begin
					ewp_ff <= ewp_ff + 1'b1;
				end
				if (ev_pop) begin
					erp_ff <= erp_ff + 1'b1;
				end
				if (ev_push && !ev_pop) begin
					ecnt_ff <= ecnt_ff + 1'b1;
				end else if (ev_pop && !ev_push) begin
					ecnt_ff <= ecnt_ff - 1'b1;
				end
			end
		end
	end

	// Read data is captured in the setup phase and shown during access.
	reg [31:0] nxt_rdata;
	always @* begin
		nxt_rdata = 32'h0000_0000;
		case (idx)
		`IDX_INTR: nxt_rdata = {23'h000000, intr_ff};
		`IDX_STATUS: nxt_rdata = {28'h0000000, status};
		`IDX_EVNUM: nxt_rdata = {16'h0000, ev_mem[erp_ff], 4'h0, status};
		`IDX_V1: nxt_rdata = {24'h000000, v1_level};
		`IDX_V2: nxt_rdata = {24'h000000, v2_level};
		`IDX_CONFIG: nxt_rdata = {24'h000000, cfg_ff};
		`IDX_FIFO_HI: nxt_rdata = meb_mem[mrp_ff];
		`IDX_FIFO_LO: nxt_rdata = {16'h0000, meb_mem[mrp_ff][15:0]};
		`IDX_LOAD: nxt_rdata = {31'h00000000, load_ff};
		default: nxt_rdata = 32'h0000_0000;
		endcase
		if (!addr_ok) begin
			nxt_rdata = 32'h0000_0000;
		end
	end

	always @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			prdata <= 32'h0000_0000;
		end else if (ce && setup) begin
			prdata <= nxt_rdata;
		end
	end
endmodule // triggered_pipeline_capture

// [pkg/capture_defines.vh]
`ifndef CAPTURE_DEFINES_VH
`define CAPTURE_DEFINES_VH
// Notes on behaviour
// - Circular buffer 256x32 stores inputs each acquisition clock, length up to 255.
// - Block mode copies 3-15 oldest words after 2-3 resync cycles.
// - Gated stream mode copies oldest words every clock while trigger stays high.
// - Each trigger bumps 8-bit event count, pushed into a 256x8 event FIFO.
// - Storage halts on full buffer or external busy; busy is open-collector.
// - After reset almost-full reads 1, other status 0, interrupt register clear.
// - Interrupt requested on trigger and when almost-full flag falls to 0.
// - Trigger interrupt drops at acknowledge; full interrupt holds until flag returns.
// - Effective circular delay is programmed length plus two clocks.
// - Configuration holds busy enable, group-OR pattern and block word count.
// - Block word count zero selects gated stream mode.
// - Master tests data-not-empty before reading; empty first read is a dummy.
// - Multi-event buffer readable word by word as 32-bit words.
// - Software clock after test write stores four copies of the written byte.
// - Status bits: event not empty, data not empty, almost_full_n, busy.
// - Almost-full low stops acquisition, blocks external signals, drives busy if enabled.
// - Configuration bit 7 enables busy output; bits 0-3 hold word count.
// - Acquisition control write enables inputs with bit 8 clear, disables when set.

// Register indices; byte address is four times the index.
`define IDX_INTR 5'h00
`define IDX_STATUS 5'h02
`define IDX_EVNUM 5'h04
`define IDX_V1 5'h06
`define IDX_V2 5'h08
`define IDX_RESET 5'h0a
`define IDX_CONFIG 5'h0c
`define IDX_ACQ 5'h0e
`define IDX_FIFO_HI 5'h10
`define IDX_FIFO_LO 5'h12
`define IDX_FIFO_WR 5'h14
`define IDX_LOAD 5'h16
`define IDX_CLOCK 5'h18
`define IDX_TRIGGER 5'h1a

// Field positions.
`define CFG_BUSY_EN 7
`define ACQ_DIS_BIT 8
`define INT_LVL_HI 8
`define INT_LVL_LO 6
`define INT_ID_HI 5

// Sizes and levels.
`define PIPE_DELAY_EXTRA 2
`define ALMOST_FULL_MARGIN 9'h007
`define LEN_MAX 8'hff
`endif

// [verification/capture_checks_assertions.sv]
`timescale 1ns/1ps
module capture_checks (
	// Clock and reset.
	input wire pclk,
	input wire presetn,
	// Register bus.
	input wire psel,
	input wire penable,
	input wire [7:0] paddr,
	input wire [31:0] prdata,
	input wire pready,
	input wire pslverr,
	// Busy line and interrupter.
	input wire busy_n_o,
	input wire busy_n_oe,
	input wire irq_req,
	input wire [2:0] irq_level,
	input wire [7:0] irq_vector
);
	default clocking cb @(posedge pclk);
	endclocking
	default disable iff (!presetn);
	sequence setup_s;
		psel && !penable;
	endsequence
	sequence access_s;
		psel && penable;
	endsequence
	a_ready_always: assert property (pready)
		else $error("pready dropped");
	a_err_unmapped: assert property (psel && penable && paddr[7] |-> pslverr)
		else $error("unmapped access not refused");
	a_err_mapped: assert property (psel && penable && paddr == 8'h08 |-> !pslverr)
		else $error("status access refused");
	a_err_window: assert property (pslverr |-> psel && penable)
		else $error("error outside access phase");
	a_read_hold: assert property (setup_s ##1 access_s |=> $stable(prdata))
		else $error("read data moved during access");
	a_busy_sink: assert property (busy_n_o == 1'b0)
		else $error("busy line driven high");
	a_vector_align: assert property (irq_vector[1:0] == 2'b00)
		else $error("vector not a multiple of four");
	a_level_off: assert property (irq_level == 3'h0 |-> !irq_req)
		else $error("request with level zero");
	a_reset_quiet: assert property ($rose(presetn) |-> !irq_req && !busy_n_oe)
		else $error("busy or request out of reset");
endmodule // capture_checks
bind triggered_pipeline_capture capture_checks u_chk (.pclk(pclk), .presetn(presetn),
	.psel(psel), .penable(penable), .paddr(paddr), .prdata(prdata), .pready(pready),
	.pslverr(pslverr), .busy_n_o(busy_n_o), .busy_n_oe(busy_n_oe), .irq_req(irq_req),
	.irq_level(irq_level), .irq_vector(irq_vector));

// [verification/front_panel_source.sv]
`timescale 1ns/1ps
module front_panel_source (
	// Bench controls.
	input wire pclk,
	input wire run,
	input wire trig_req,
	input wire ext_busy,
	input wire [31:0] pattern,
	// Device side.
	input wire busy_n_oe,
	output reg acq_clk_in,
	output reg trig_in,
	output reg [31:0] data_in,
	output wire busy_n_i
);
	reg [2:0] div_ff;
	initial begin
		div_ff = 3'h0;
		acq_clk_in = 1'b0;
		trig_in = 1'b0;
		data_in = 32'h0;
	end
	// The acquisition clock stands still while the source is idle.
	always @(posedge pclk) begin
		div_ff <= run ? div_ff + 3'h1 : 3'h0;
		acq_clk_in <= run & div_ff[2];
		trig_in <= trig_req;
		data_in <= pattern;
	end
	// The shared busy line has a pull-up and any unit may pull it low.
	assign busy_n_i = ~(busy_n_oe | ext_busy);
endmodule // front_panel_source

// [verification/tb_triggered_pipeline_capture.sv]
`timescale 1ns/1ps
`include "capture_defines.vh"
module tb_triggered_pipeline_capture;
	reg pclk = 1'b0, presetn = 1'b0, psel = 1'b0, penable = 1'b0, pwrite = 1'b0;
	reg irq_ack = 1'b0, run = 1'b0, trig_req = 1'b0, ext_busy = 1'b0, last_err;
	reg [7:0] paddr = 8'h00;
	reg [31:0] pwdata = 32'h0, pattern = 32'h0, seed_ff = 32'h00015ece, rd;
	wire [31:0] prdata, data_in;
	wire pready, pslverr, acq_clk_in, trig_in, busy_n_i, busy_n_o, busy_n_oe, irq_req;
	wire [2:0] irq_level;
	wire [7:0] irq_vector;
	wire [15:0] group_or_output;
	wire or_out;
	integer err_total = 0, samples_checked = 0, i, k;
	always #12.5 pclk = ~pclk;
	triggered_pipeline_capture u_dut (.pclk(pclk), .presetn(presetn), .ce(1'b1),
		.psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
		.prdata(prdata), .pready(pready), .pslverr(pslverr), .data_in(data_in),
		.acq_clk_in(acq_clk_in), .trig_in(trig_in), .or_in(1'b0), .busy_n_i(busy_n_i),
		.busy_n_o(busy_n_o), .busy_n_oe(busy_n_oe), .or_out(or_out),
		.group_or_output(group_or_output),
		.v1_level(), .v2_level(), .irq_ack(irq_ack), .irq_req(irq_req),
		.irq_level(irq_level), .irq_vector(irq_vector));
	front_panel_source u_src (.pclk(pclk), .run(run), .trig_req(trig_req),
		.ext_busy(ext_busy), .pattern(pattern), .busy_n_oe(busy_n_oe),
		.acq_clk_in(acq_clk_in), .trig_in(trig_in), .data_in(data_in), .busy_n_i(busy_n_i));
	function [31:0] lfsr(input [31:0] s);
		lfsr = {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
	endfunction
	function [31:0] rep(input [7:0] b);
		rep = {4{b}};
	endfunction
	// Each set input bit lights the group that holds it; groups are 2, 4, 8 or 16 bits wide.
	function [15:0] gor(input [31:0] d, input [1:0] m);
		integer j;
		gor = 16'h0000;
		for (j = 0; j < 32; j = j + 1)
			if (d[j])
				gor[j >> (m + 1)] = 1'b1;
	endfunction
	task check(input string what, input [31:0] seen, input [31:0] exp);
		samples_checked = samples_checked + 1;
		if (seen !== exp) begin
			$display("MISMATCH %s expected %h seen %h", what, exp, seen);
			err_total = err_total + 1;
		end
	endtask
	task apb(input w, input [7:0] a, input [31:0] d);
		@(posedge pclk);
		psel <= 1'b1;
		penable <= 1'b0;
		pwrite <= w;
		paddr <= a;
		pwdata <= d;
		@(posedge pclk);
		penable <= 1'b1;
		@(posedge pclk);
		while (pready !== 1'b1)
			@(posedge pclk);
		rd = prdata;
		last_err = pslverr;
		psel <= 1'b0;
		penable <= 1'b0;
	endtask
	task wr(input [4:0] x, input [31:0] d);
		apb(1'b1, {1'b0, x, 2'b00}, d);
	endtask
	task rg(input [4:0] x);
		apb(1'b0, {1'b0, x, 2'b00}, 32'h0);
	endtask
	task tick(input [7:0] b);
		wr(`IDX_FIFO_WR, {24'h0, b});
		wr(`IDX_CLOCK, 32'h0);
	endtask
	task conclude;
		if (err_total == 0 && samples_checked > 0)
			$display("verification passed");
		else
			$display("verification failed");
		$finish;
	endtask
	initial begin
		repeat (10000) @(posedge pclk);
		err_total = err_total + 1;
		conclude;
	end
	initial begin
		repeat (5) @(posedge pclk);
		presetn <= 1'b1;
		rg(`IDX_STATUS);
		check("status", rd & 32'hf, 32'h4);
		rg(`IDX_INTR);
		check("intr", rd, 32'h0);
		apb(1'b0, 8'h80, 32'h0);
		check("slverr", {31'h0, last_err}, 32'h1);
		// Acquisition is still disabled, so only software clocks and triggers act.
		for (i = 0; i < 3; i = i + 1) begin
			k = (i == 0) ? 3 : (i == 1) ? 7 : 15;
			seed_ff = lfsr(seed_ff);
			wr(`IDX_CONFIG, k);
			repeat (4) tick(seed_ff[7:0]);
			wr(`IDX_TRIGGER, 32'h0);
			repeat (k + 4) tick(seed_ff[7:0]);
			rg(`IDX_EVNUM);
			check("event", rd & 32'hff03, (i << 8) | 3);
			repeat (k) begin
				rg(`IDX_FIFO_HI);
				check("word", rd, rep(seed_ff[7:0]));
			end
			rg(`IDX_STATUS);
			check("drained", rd & 32'h2, 32'h0);
		end
		// Circular length 5 gives a delay of seven ticks.
		wr(`IDX_LOAD, 32'h0);
		wr(`IDX_RESET, 32'h0);
		tick(8'h00);
		tick(8'hfa);
		tick(8'h00);
		wr(`IDX_LOAD, 32'h1);
		wr(`IDX_CONFIG, 32'h3);
		for (i = 1; i <= 30; i = i + 1)
			tick(i[7:0]);
		wr(`IDX_TRIGGER, 32'h0);
		for (i = 31; i <= 36; i = i + 1)
			tick(i[7:0]);
		for (i = 0; i < 3; i = i + 1) begin
			rg(`IDX_FIFO_HI);
			check("delay", rd, rep(8'h18 + i[7:0]));
		end
		wr(`IDX_INTR, 32'h95);
		rg(`IDX_INTR);
		check("intr", rd & 32'h1ff, 32'h95);
		check("vector", {24'h0, irq_vector}, 32'h54);
		check("level", {29'h0, irq_level}, 32'h2);
		// The software trigger above left its interrupt pending; clear it first.
		check("soft irq", {31'h0, irq_req}, 32'h1);
		irq_ack <= 1'b1;
		@(posedge pclk);
		irq_ack <= 1'b0;
		@(posedge pclk);
		check("ack", {31'h0, irq_req}, 32'h0);
		wr(`IDX_CONFIG, 32'h80);
		wr(`IDX_ACQ, 32'h0);
		seed_ff = lfsr(seed_ff);
		pattern <= seed_ff;
		run <= 1'b1;
		repeat (200) @(posedge pclk);
		ext_busy <= 1'b1;
		trig_req <= 1'b1;
		repeat (200) @(posedge pclk);
		rg(`IDX_STATUS);
		check("halt", rd & 32'h2, 32'h0);
		check("trig irq", {31'h0, irq_req}, 32'h1);
		irq_ack <= 1'b1;
		@(posedge pclk);
		irq_ack <= 1'b0;
		@(posedge pclk);
		check("ack", {31'h0, irq_req}, 32'h0);
		ext_busy <= 1'b0;
		while (busy_n_oe !== 1'b1)
			@(posedge pclk);
		trig_req <= 1'b0;
		run <= 1'b0;
		rg(`IDX_STATUS);
		check("full", rd & 32'hc, 32'h8);
		check("full irq", {31'h0, irq_req}, 32'h1);
		check("busy out", {31'h0, busy_n_oe}, 32'h1);
		for (i = 0; i < 16 && rd[2] !== 1'b1; i = i + 1) begin
			rg(`IDX_FIFO_HI);
			check("stream", rd, pattern);
			rg(`IDX_STATUS);
		end
		check("relieved", {31'h0, rd[2]}, 32'h1);
		check("irq off", {31'h0, irq_req}, 32'h0);
		wr(`IDX_ACQ, 32'h100);
		// The pattern still stands on the inputs, so every OR grouping can be compared.
		for (i = 0; i < 4; i = i + 1) begin
			wr(`IDX_CONFIG, i << 4);
			repeat (2) @(posedge pclk);
			check("group or", {16'h0, group_or_output}, {16'h0, gor(pattern, i[1:0])});
		end
		check("or out", {31'h0, or_out}, {31'h0, |pattern});
		conclude;
	end
endmodule // tb_triggered_pipeline_capture
